// >>> inc/dcce_pkg.sv
// Package for the channel correction engine: register map, field
// layouts, reset values and the packed carriers shared with the top.
// Assumes a 32-bit Avalon-MM slave view with word-aligned registers.
package dcce_pkg;
  // --------------------------------------------------------------------
  // Geometry
  // --------------------------------------------------------------------
  localparam int unsigned NUM_CH        = 8;
  localparam int unsigned CH_W          = 3;
  localparam int unsigned CODE_W        = 12;
  localparam int unsigned GROUP_SIZE    = 4;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;

  // --------------------------------------------------------------------
  // Register map (byte addresses); per-channel blocks stride 4 bytes
  // --------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CFG_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] INPUT_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] GAIN_BASE  = 8'h40;
  localparam logic [ADDR_W-1:0] ZERO_BASE  = 8'h60;
  localparam logic [ADDR_W-1:0] OUT_BASE   = 8'h80;
  localparam logic [ADDR_W-1:0] BLK_MASK   = 8'he0;
  localparam int unsigned       CH_LSB     = 2;

  // Config / status fields
  localparam int unsigned CFG_CE_BIT     = 0;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_PEND_LSB  = 8;

  // --------------------------------------------------------------------
  // Reset values and arithmetic constants
  // --------------------------------------------------------------------
  localparam logic [CODE_W-1:0] GAIN_RST   = 12'h800;
  localparam logic [CODE_W-1:0] ZERO_RST   = 12'h000;
  localparam logic [CODE_W-1:0] INPUT_RST  = 12'h000;
  localparam logic              CE_RST     = 1'b0;
  localparam logic [CODE_W:0]   GAIN_BIAS  = 13'h0800;
  localparam int unsigned       PROD_SHIFT = 12;
  localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0000_0000;

  typedef logic [CODE_W-1:0] dcce_code_t;

  // Engine request carrier: one channel's operands
  typedef struct packed {
    logic [CH_W-1:0] ch;
    dcce_code_t      input_code;
    dcce_code_t      gain;
    dcce_code_t      zero;
  } dcce_req_s;

  // Converter latch feed
  typedef struct packed {
    logic [NUM_CH*CODE_W-1:0] codes;
    logic [1:0]               group_upd;
  } dcce_out_s;
endpackage : dcce_pkg

// >>> logic/dcce_top.sv
// Channel correction engine: eight gain/zero calibration channels,
// one shared multiply-add engine, Avalon-MM register slave.
// Assumes one 200 MHz clock and an Avalon master that honours
// waitrequest; the converter latch sits outside and reads out_o.
//
// Notes on behaviour
// - Each channel owns separate gain and zero registers.
// - Enabled: result is input scaled by gain, plus zero, into output.
// - Enabled: writing input, gain or zero recomputes that channel automatically.
// - Effective multiplier spans one half to one and a half.
// - Zero correction spans -2048 to +2047 code steps.
// - One engine serves all eight channels, one at a time.
// - Correction-enable bit 0 disables the engine, 1 enables it.
// - Disabled: written input code copies unchanged to output.
// - Disabled: gain/zero writes store but never touch output.
// - Gain and zero read back exactly as written.
// - Latch code is 12-bit unsigned binary.
// - Channels 0-3 form group A, 4-7 form group B.
// - Result = (input*(gain+2048))/4096 + signed zero.
// - Reset: gain 2048, zero 0.
// - Gain unsigned, zero twos complement, whatever the data format.
`timescale 1ns/1ps
`default_nettype none

module dcce_top (
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_i,
  input  wire logic [dcce_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [dcce_pkg::DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic      [dcce_pkg::DATA_W-1:0] avs_readdata_o,
  output logic                          avs_waitrequest_o,
  output logic      [dcce_pkg::NUM_CH*dcce_pkg::CODE_W-1:0] out_o,
  output logic      [1:0]               group_upd_o,
  output logic                          busy_o
);
  import dcce_pkg::*;

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  dcce_code_t        input_r [NUM_CH];
  dcce_code_t        gain_r  [NUM_CH];
  dcce_code_t        zero_r  [NUM_CH];
  dcce_code_t        out_r   [NUM_CH];
  logic              ce_r;
  logic [NUM_CH-1:0] pend_r;
  logic              eng_vld_r;
  dcce_req_s         eng_req_r;
  logic              ack_r;
  logic [DATA_W-1:0] rdata_r;
  dcce_out_s         lat_r;

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  function automatic logic blk_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] base);
    blk_hit = (a & BLK_MASK) == base;
  endfunction

  logic [CH_W-1:0] ch_idx;
  logic            req;
  logic            wr_go;
  logic            rd_go;
  logic            wr_in;
  logic            wr_gain;
  logic            wr_zero;
  logic            wr_cfg;
  assign ch_idx  = avs_address_i[CH_LSB +: CH_W];
  assign req     = avs_read_i | avs_write_i;
  // Every access waits exactly one cycle, then completes
  assign wr_go   = avs_write_i & ack_r;
  assign rd_go   = avs_read_i & ack_r;
  // Byte lanes 0 and 1 carry the 12-bit code; partial writes merge
  assign wr_in   = wr_go & blk_hit(avs_address_i, INPUT_BASE);
  assign wr_gain = wr_go & blk_hit(avs_address_i, GAIN_BASE);
  assign wr_zero = wr_go & blk_hit(avs_address_i, ZERO_BASE);
  assign wr_cfg  = wr_go & (avs_address_i == CFG_OFS) & avs_byteenable_i[0];

  function automatic dcce_code_t merge(input dcce_code_t old);
    merge[7:0]  = avs_byteenable_i[0] ? avs_writedata_i[7:0] : old[7:0];
    merge[11:8] = avs_byteenable_i[1] ? avs_writedata_i[11:8] : old[11:8];
  endfunction

  // --------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------
  // Waitrequest is always the inverse of ack_r; both registered, so every
  // access is a fixed two-cycle affair with no combinational bus path
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      // Waitrequest drops in the second cycle of a request
      avs_waitrequest_o <= ~(req & ~ack_r);
    end
  end

  // Read data registered in the first cycle, valid when waitrequest low
  // Reads have no side effects, so an abandoned read costs nothing
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= UNMAPPED_RD;
    end else if (avs_read_i & ~ack_r) begin
      rdata_r <= UNMAPPED_RD;
      if (avs_address_i == CFG_OFS) begin
        rdata_r[CFG_CE_BIT] <= ce_r;
      end else if (avs_address_i == STAT_OFS) begin
        rdata_r[STAT_BUSY_BIT] <= eng_vld_r | (|pend_r);
        rdata_r[STAT_PEND_LSB +: NUM_CH] <= pend_r;
      end else if (blk_hit(avs_address_i, INPUT_BASE)) begin
        rdata_r[CODE_W-1:0] <= input_r[ch_idx];
      end else if (blk_hit(avs_address_i, GAIN_BASE)) begin
        rdata_r[CODE_W-1:0] <= gain_r[ch_idx];
      end else if (blk_hit(avs_address_i, ZERO_BASE)) begin
        rdata_r[CODE_W-1:0] <= zero_r[ch_idx];
      end else if (blk_hit(avs_address_i, OUT_BASE)) begin
        rdata_r[CODE_W-1:0] <= out_r[ch_idx];
      end
    end
  end
  assign avs_readdata_o = rdata_r;

  // --------------------------------------------------------------------
  // Configuration
  // --------------------------------------------------------------------
  // Toggling the enable does not recompute; software rewrites a channel
  // to refresh its output under the new mode
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ce_r <= CE_RST;
    end else if (wr_cfg) begin
      ce_r <= avs_writedata_i[CFG_CE_BIT];
    end
  end

  // --------------------------------------------------------------------
  // Per-channel registers
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic sel;
      assign sel = ch_idx == CH_W'(g);
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
          input_r[g] <= INPUT_RST;
          gain_r[g]  <= GAIN_RST;
          zero_r[g]  <= ZERO_RST;
        end else begin
          if (wr_in & sel)   input_r[g] <= merge(input_r[g]);
          // Stored as raw bits; no format conversion
          if (wr_gain & sel) gain_r[g]  <= merge(gain_r[g]);
          if (wr_zero & sel) zero_r[g]  <= merge(zero_r[g]);
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Request queue and arbiter
  // --------------------------------------------------------------------
  logic            pick_vld;
  logic [CH_W-1:0] pick_ch;
  always_comb begin
    pick_vld = 1'b0;
    pick_ch  = '0;
    // Lowest channel first; a pending bit is never dropped
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        pick_vld = 1'b1;
        pick_ch  = CH_W'(i);
      end
    end
  end

  // Fixed priority is fair enough: the engine frees every two cycles,
  // as fast as the bus can queue a new request
  logic take;
  assign take = pick_vld & ~eng_vld_r;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        // New request wins over the grant clearing the same bit
        if (ce_r & (wr_in | wr_gain | wr_zero) & (ch_idx == CH_W'(i))) begin
          pend_r[i] <= 1'b1;
        end else if (take & (pick_ch == CH_W'(i))) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // Operands captured at grant; a later write re-queues the channel
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      eng_vld_r <= 1'b0;
      eng_req_r <= '0;
    end else begin
      eng_vld_r <= take;
      if (take) begin
        eng_req_r.ch         <= pick_ch;
        eng_req_r.input_code <= input_r[pick_ch];
        eng_req_r.gain       <= gain_r[pick_ch];
        eng_req_r.zero       <= zero_r[pick_ch];
      end
    end
  end

  // --------------------------------------------------------------------
  // Engine datapath
  // --------------------------------------------------------------------
  logic [CODE_W:0]      eff_gain;
  logic [2*CODE_W:0]    prod;
  logic signed [CODE_W+1:0] sum;
  dcce_code_t           result;
  // Gain 0..4095 maps to 2048..6143, i.e. x0.5..x1.5
  assign eff_gain = {1'b0, eng_req_r.gain} + GAIN_BIAS;
  assign prod     = (2*CODE_W+1)'(eng_req_r.input_code) *
                    (2*CODE_W+1)'(eff_gain);
  // Quotient keeps 13 bits: gains above unity can push it past 4095,
  // and dropping the top bit would wrap instead of clamping
  assign sum = $signed({1'b0, prod[PROD_SHIFT +: CODE_W+1]}) +
               $signed({{2{eng_req_r.zero[CODE_W-1]}},
                        eng_req_r.zero});
  always_comb begin
    if (sum < 0) result = '0;
    else if (sum[CODE_W]) result = '1;
    else result = sum[CODE_W-1:0];
  end

  // --------------------------------------------------------------------
  // Output data registers
  // --------------------------------------------------------------------
  // Engine result wins over a bypass copy to the same channel; the two
  // only meet when the enable drops with a request still in flight
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_CH; i++) out_r[i] <= INPUT_RST;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (eng_vld_r & (eng_req_r.ch == CH_W'(i))) begin
          out_r[i] <= result;
        end else if (~ce_r & wr_in & (ch_idx == CH_W'(i))) begin
          out_r[i] <= merge(input_r[i]);
        end
      end
    end
  end

  // Latch copy trails the output register by one cycle; group flags
  // compare old and new, so an unchanged rewrite raises no flag
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lat_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        lat_r.codes[i*CODE_W +: CODE_W] <= out_r[i];
      end
      // Group flag pulses when any channel of the group changed
      for (int k = 0; k < 2; k++) begin
        lat_r.group_upd[k] <= 1'b0;
        for (int i = 0; i < GROUP_SIZE; i++) begin
          if (lat_r.codes[(k*GROUP_SIZE+i)*CODE_W +: CODE_W] !=
              out_r[k*GROUP_SIZE+i]) begin
            lat_r.group_upd[k] <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= take | (|pend_r) | eng_vld_r;
    end
  end

  assign out_o       = lat_r.codes;
  assign group_upd_o = lat_r.group_upd;

endmodule // dcce_top

`default_nettype wire

// >>> test/dcce_top_chk.sv
// Checker for the correction engine top: bus and output timing.
// Bound to dcce_top from the bench top file; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module dcce_top_chk
  import dcce_pkg::*;
(
  input wire logic                     sys_clk_i,
  input wire logic                     reset_i,
  input wire logic [ADDR_W-1:0]        avs_address_i,
  input wire logic                     avs_read_i,
  input wire logic                     avs_write_i,
  input wire logic [DATA_W-1:0]        avs_writedata_i,
  input wire logic [3:0]               avs_byteenable_i,
  input wire logic [DATA_W-1:0]        avs_readdata_o,
  input wire logic                     avs_waitrequest_o,
  input wire logic [NUM_CH*CODE_W-1:0] out_o,
  input wire logic [1:0]               group_upd_o,
  input wire logic                     busy_o
);
  logic              wr_done;
  logic [ADDR_W-1:0] blk;
  logic [CH_W-1:0]   ch;
  logic              ce_r;
  assign wr_done = avs_write_i && !avs_waitrequest_o;
  assign blk = avs_address_i & BLK_MASK;
  assign ch = avs_address_i[CH_LSB+:CH_W];
  // Enable shadow, so checks know which mode a write lands in
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ce_r <= CE_RST;
    end else if (wr_done && avs_address_i == CFG_OFS
                 && avs_byteenable_i[0]) begin
      ce_r <= avs_writedata_i[CFG_CE_BIT];
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  chk_wait_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest not low one cycle after request");
  chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  chk_bypass_copy: assert property (
    wr_done && !ce_r && blk == INPUT_BASE |-> ##2
    out_o[CODE_W*$past(ch, 2)+:CODE_W] == $past(avs_writedata_i[11:0], 2))
    else $error("bypass input not copied to output");
  chk_bypass_hold: assert property (
    wr_done && !ce_r && (blk == GAIN_BASE || blk == ZERO_BASE)
    |=> $stable(out_o)[*2])
    else $error("bypass gain or zero write moved output");
  chk_engine_off: assert property (!ce_r && !busy_o |=> !busy_o)
    else $error("engine started while disabled");
  chk_start_calc: assert property (
    wr_done && ce_r && (blk == INPUT_BASE || blk == GAIN_BASE
    || blk == ZERO_BASE) |-> ##[1:2] busy_o)
    else $error("write did not start a correction");
  chk_group_a: assert property (
    $changed(out_o[47:0]) |-> ##[0:2] group_upd_o[0])
    else $error("group a update not flagged");
  chk_group_b: assert property (
    $changed(out_o[95:48]) |-> ##[0:2] group_upd_o[1])
    else $error("group b update not flagged");
  chk_one_per_two: assert property (
    $changed(out_o) |=> $stable(out_o))
    else $error("outputs changed in consecutive cycles");
endmodule // dcce_top_chk
`default_nettype wire

// >>> test/dcce_top_tb_top.sv
// Bench top for the correction engine: bus tasks and directed tests.
// Assumes the register map and timing of the engine package.
`timescale 1ns/1ps
`default_nettype none
module dcce_top_tb_top;
  import dcce_pkg::*;
  logic                     sys_clk_i = 1'b0;
  logic                     reset_i = 1'b1;
  logic [ADDR_W-1:0]        avs_address_i = '0;
  logic                     avs_read_i = 1'b0;
  logic                     avs_write_i = 1'b0;
  logic [DATA_W-1:0]        avs_writedata_i = '0;
  logic [3:0]               avs_byteenable_i = 4'hf;
  logic [DATA_W-1:0]        avs_readdata_o;
  logic                     avs_waitrequest_o;
  logic [NUM_CH*CODE_W-1:0] out_o;
  logic [1:0]               group_upd_o;
  logic                     busy_o;
  logic [31:0]              rdat;
  int                       n_errors = 0;
  int                       n_tests = 0;
  logic [11:0] ci [8] = '{12'hfff, 12'h800, 12'h400, 12'h000,
                          12'hfff, 12'h100, 12'hc00, 12'h7ff};
  logic [11:0] cg [8] = '{12'h000, 12'hfff, 12'h800, 12'h555,
                          12'hfff, 12'h800, 12'h000, 12'h200};
  logic [11:0] cz [8] = '{12'h000, 12'h7ff, 12'h800, 12'h001,
                          12'h000, 12'h800, 12'h010, 12'hfff};

  always #2.5 sys_clk_i = ~sys_clk_i;

  dcce_top uut (.sys_clk_i, .reset_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .out_o, .group_upd_o, .busy_o);

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    rdat = avs_readdata_o;
    chk("bus answer", 32'h1, {31'h0, n < 64});
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  // Poll busy, then let the latch copy land
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge sys_clk_i);
    while (busy_o !== 1'b0 && n < 200) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk("engine idle", 32'h1, {31'h0, n < 200});
    repeat (2) @(posedge sys_clk_i);
  endtask

  function automatic logic [11:0] model(input logic [11:0] x, g, z);
    int r;
    r = (int'(x) * (int'(g) + 2048)) / 4096 + int'($signed(z));
    if (r < 0) r = 0;
    if (r > 4095) r = 4095;
    return r[11:0];
  endfunction

  task automatic chk_out(input int c, input logic [11:0] e);
    access(1'b0, OUT_BASE + 8'(4 * c), '0);
    chk("output reg", {20'h0, e}, rdat);
    chk("output latch", {20'h0, e}, {20'h0, out_o[12*c+:12]});
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 5);
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      access(1'b0, GAIN_BASE + 8'(4 * c), '0);
      chk("gain reset", 32'h800, rdat);
      access(1'b0, ZERO_BASE + 8'(4 * c), '0);
      chk("zero reset", 32'h0, rdat);
      chk_out(c, 12'h0);
    end
    $display("test reset values done");
    for (int c = 0; c < 8; c++) begin
      access(1'b1, INPUT_BASE + 8'(4 * c), {20'h0, ci[c]});
      access(1'b1, GAIN_BASE + 8'(4 * c), {20'h0, cg[c]});
      access(1'b1, ZERO_BASE + 8'(4 * c), {20'h0, cz[c]});
    end
    for (int c = 0; c < 8; c++) begin
      chk_out(c, ci[c]);
      access(1'b0, GAIN_BASE + 8'(4 * c), '0);
      chk("gain readback", {20'h0, cg[c]}, rdat);
      access(1'b0, ZERO_BASE + 8'(4 * c), '0);
      chk("zero readback", {20'h0, cz[c]}, rdat);
    end
    access(1'b0, 8'h0c, '0);
    chk("unmapped read", 32'h0, rdat);
    $display("test bypass done");
    access(1'b1, CFG_OFS, 32'h1);
    for (int c = 0; c < 8; c++) begin
      access(1'b1, INPUT_BASE + 8'(4 * c), {20'h0, ci[c]});
      wait_idle();
      chk_out(c, model(ci[c], cg[c], cz[c]));
      access(1'b1, GAIN_BASE + 8'(4 * c), 32'h800);
      wait_idle();
      chk_out(c, model(ci[c], 12'h800, cz[c]));
    end
    $display("test correction done");
    for (int c = 7; c >= 0; c--) begin
      access(1'b1, ZERO_BASE + 8'(4 * c), 32'h0);
    end
    access(1'b0, STAT_OFS, '0);
    chk("status busy", 32'h1, rdat);
    wait_idle();
    access(1'b0, STAT_OFS, '0);
    chk("status idle", 32'h0, rdat);
    for (int c = 0; c < 8; c++) begin
      chk_out(c, model(ci[c], 12'h800, 12'h0));
      access(1'b0, GAIN_BASE + 8'(4 * c), '0);
      chk("gain readback", 32'h800, rdat);
    end
    $display("test queue done");
    access(1'b1, CFG_OFS, 32'h0);
    access(1'b1, INPUT_BASE, 32'h123);
    chk_out(0, 12'h123);
    $display("test disable done");
    stop_test();
  end
endmodule // dcce_top_tb_top

bind dcce_top dcce_top_chk chk_u (.sys_clk_i, .reset_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_readdata_o, .avs_waitrequest_o, .out_o, .group_upd_o, .busy_o);
`default_nettype wire
